// ==== logic/ssp_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1: port active only while interface select high
// RQ2: slave only, four wire full duplex
// RQ3: incomplete flag bit 0; counter cleared deselected
// RQ4: polarity bit 5: 0 idle high
// RQ5: edge bit 4 picks capture edge
// RQ6: order bit 3: 0 lsb first
// RQ7: select control bit 2 enables select pin
// RQ8: select control off means always selected
// RQ9: write during transfer dropped, collision flag set
// RQ10: unimplemented control bits read zero
// RQ11: each clock shifts out and in
// RQ12: master selects before any clock
// RQ13: clock format fixed before transfers
// RQ14: command byte: rw bit 7, address 4:0
// RQ15: write command then one data byte
// RQ16: read command then addressed register returned
// RQ17: deselect abandons partial command or byte
module ssp_dev
	import ssp_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	ssp_link_if.dev link,
	input wire logic [5:0] I_LOCAL_ADDR,
	input wire logic [7:0] I_LOCAL_WDATA,
	input wire logic I_LOCAL_WR,
	input wire logic I_LOCAL_RD,
	output logic [7:0] O_LOCAL_RDATA,
	output logic O_IRQ
);
	logic [3:0] pin_raw;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic sclk_d;
	logic sclk_s;
	logic ss_n_s;
	logic mosi_s;
	logic ifsel_s;
	logic selected;
	logic sel_d;
	logic rise;
	logic fall;
	logic cap_rise;
	logic capture;
	logic launch;
	logic byte_done;
	logic busy;
	logic [2:0] bit_cnt;
	ssp_phase_e phase;
	logic [7:0] rx_byte;
	logic [7:0] next_rx;
	logic [7:0] tx_byte;
	logic cmd_read;
	logic [4:0] cmd_addr;
	logic [7:0] regfile [REG_COUNT];
	logic spi_wr;
	logic local_reg_wr;
	logic collide;
	logic incomplete_ev;
	logic incomplete_flag;
	logic write_collision_flag;
	logic ckpol;
	logic capture_edge_select;
	logic shift_order_select;
	logic select_pin_control;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [2:0] irq_events;
	logic [7:0] status_rd;
	logic [7:0] format_rd;

	assign pin_raw = {link.sclk, link.ss_n, link.mosi, link.if_sel};

	// two-stage synchronisers for the pins
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++)
		begin : g_sync
			always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
			begin
				if (!I_RST_N)
				begin
					pin_s1[gp] <= 1'b0;
					pin_s2[gp] <= 1'b0;
				end
				else
				begin
					pin_s1[gp] <= pin_raw[gp];
					pin_s2[gp] <= pin_s1[gp];
				end
			end
		end
	endgenerate

	assign sclk_s = pin_s2[3];
	assign ss_n_s = pin_s2[2];
	assign mosi_s = pin_s2[1];
	assign ifsel_s = pin_s2[0];

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sclk_d <= 1'b0;
			sel_d <= 1'b0;
		end
		else
		begin
			sclk_d <= sclk_s;
			sel_d <= selected;
		end
	end

	// select decode; select pin ignored when disabled
	assign selected = ifsel_s & (~select_pin_control | ~ss_n_s); // [RQ1] [RQ2] [RQ7] [RQ8]
	assign rise = sclk_s & ~sclk_d;
	assign fall = ~sclk_s & sclk_d;
	assign cap_rise = ~(ckpol ^ capture_edge_select); // [RQ4] [RQ5]
	assign capture = selected & (cap_rise ? rise : fall); // [RQ5] [RQ11]
	assign launch = selected & (cap_rise ? fall : rise); // [RQ11]
	assign byte_done = capture & (bit_cnt == BIT_LAST);
	assign next_rx = shift_order_select ? {rx_byte[6:0], mosi_s} : {mosi_s, rx_byte[7:1]}; // [RQ6]
	assign busy = selected & ((bit_cnt != 3'h0) | (phase == PH_DATA));

	// bit counter
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			bit_cnt <= 3'h0;
		else if (!selected)
			bit_cnt <= 3'h0; // [RQ3]
		else if (capture)
			bit_cnt <= 3'(bit_cnt + 3'h1);
	end

	// receive shifter
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			rx_byte <= 8'h00;
		else if (!selected)
			rx_byte <= 8'h00; // [RQ17]
		else if (capture)
			rx_byte <= next_rx; // [RQ11]
	end

	// transaction phase
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			phase <= PH_CMD;
		else if (!selected)
			phase <= PH_CMD; // [RQ17]
		else if (byte_done)
		begin
			unique case (phase)
				PH_CMD: phase <= PH_DATA; // [RQ14]
				PH_DATA: phase <= PH_DONE;
				PH_DONE: phase <= PH_DONE;
			endcase
		end
	end

	// command decode, reserved bits ignored
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			cmd_read <= 1'b0;
			cmd_addr <= 5'h00;
		end
		else if (byte_done && phase == PH_CMD)
		begin
			cmd_read <= next_rx[CMD_RW_BIT]; // [RQ14]
			cmd_addr <= next_rx[4:0]; // [RQ16]
		end
	end

	// transmit byte: zero except the read data byte
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			tx_byte <= 8'h00;
		else if (!selected)
			tx_byte <= 8'h00;
		else if (byte_done && phase == PH_CMD && next_rx[CMD_RW_BIT])
			tx_byte <= regfile[next_rx[4:0]]; // [RQ16]
		else if (byte_done)
			tx_byte <= 8'h00;
	end

	// output data on the launch edge
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			link.miso <= 1'b0;
		else if (!selected)
			link.miso <= 1'b0;
		else if (launch)
			link.miso <= shift_order_select ? tx_byte[3'(BIT_LAST - bit_cnt)] : tx_byte[bit_cnt]; // [RQ6] [RQ11] [RQ16]
	end

	// register file writes
	assign spi_wr = byte_done & (phase == PH_DATA) & ~cmd_read; // [RQ15]
	assign local_reg_wr = I_LOCAL_WR & (I_LOCAL_ADDR <= OFS_REGFILE_LAST);
	assign collide = local_reg_wr & busy; // [RQ9]

	genvar gr;
	generate
		for (gr = 0; gr < REG_COUNT; gr++)
		begin : g_reg
			always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
			begin
				if (!I_RST_N)
					regfile[gr] <= REGFILE_RESET;
				else if (spi_wr && cmd_addr == 5'(gr))
					regfile[gr] <= next_rx; // [RQ15]
				else if (local_reg_wr && !busy && I_LOCAL_ADDR[4:0] == 5'(gr))
					regfile[gr] <= I_LOCAL_WDATA; // [RQ9]
			end
		end
	endgenerate

	// incomplete flag, set wins over clear
	assign incomplete_ev = sel_d & ~selected & ((bit_cnt != 3'h0) | (phase == PH_DATA)); // [RQ3]

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			incomplete_flag <= STATUS_RESET[INCOMPLETE_BIT];
		else if (incomplete_ev)
			incomplete_flag <= 1'b1; // [RQ3]
		else if (I_LOCAL_WR && I_LOCAL_ADDR == OFS_INCOMPLETE_STATUS)
			incomplete_flag <= I_LOCAL_WDATA[INCOMPLETE_BIT];
	end

	// clock format control
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			ckpol <= FORMAT_RESET[CKPOL_BIT];
			capture_edge_select <= FORMAT_RESET[CAPTURE_EDGE_SELECT_BIT];
			shift_order_select <= FORMAT_RESET[MLS_BIT];
			select_pin_control <= FORMAT_RESET[SELECT_PIN_CONTROL_BIT];
		end
		else if (I_LOCAL_WR && I_LOCAL_ADDR == OFS_CLOCK_FORMAT)
		begin
			ckpol <= I_LOCAL_WDATA[CKPOL_BIT]; // [RQ4]
			capture_edge_select <= I_LOCAL_WDATA[CAPTURE_EDGE_SELECT_BIT]; // [RQ5]
			shift_order_select <= I_LOCAL_WDATA[MLS_BIT]; // [RQ6]
			select_pin_control <= I_LOCAL_WDATA[SELECT_PIN_CONTROL_BIT]; // [RQ7]
		end
	end

	// collision flag, set wins over clear
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			write_collision_flag <= FORMAT_RESET[WRITE_COLLISION_FLAG_BIT];
		else if (collide)
			write_collision_flag <= 1'b1; // [RQ9]
		else if (I_LOCAL_WR && I_LOCAL_ADDR == OFS_CLOCK_FORMAT)
			write_collision_flag <= I_LOCAL_WDATA[WRITE_COLLISION_FLAG_BIT];
	end

	// interrupt status and mask
	always_comb
	begin
		irq_events = 3'h0;
		irq_events[EV_WRITE_BIT] = spi_wr;
		irq_events[EV_INCOMPLETE_BIT] = incomplete_ev;
		irq_events[EV_COLLISION_BIT] = collide;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			irq_status <= IRQ_RESET;
		else if (I_LOCAL_WR && I_LOCAL_ADDR == OFS_IRQ_STATUS)
			irq_status <= (irq_status & ~I_LOCAL_WDATA[2:0]) | irq_events;
		else
			irq_status <= irq_status | irq_events;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			irq_mask <= IRQ_RESET;
		else if (I_LOCAL_WR && I_LOCAL_ADDR == OFS_IRQ_MASK)
			irq_mask <= I_LOCAL_WDATA[2:0];
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_IRQ <= 1'b0;
		else
			O_IRQ <= |(irq_status & irq_mask);
	end

	// local read port, data valid one cycle after strobe
	always_comb
	begin
		status_rd = 8'h00;
		status_rd[INCOMPLETE_BIT] = incomplete_flag; // [RQ10]
		format_rd = 8'h00;
		format_rd[CKPOL_BIT] = ckpol;
		format_rd[CAPTURE_EDGE_SELECT_BIT] = capture_edge_select;
		format_rd[MLS_BIT] = shift_order_select;
		format_rd[SELECT_PIN_CONTROL_BIT] = select_pin_control;
		format_rd[WRITE_COLLISION_FLAG_BIT] = write_collision_flag; // [RQ10]
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_LOCAL_RDATA <= 8'h00;
		else if (!I_LOCAL_RD)
			O_LOCAL_RDATA <= 8'h00;
		else if (I_LOCAL_ADDR <= OFS_REGFILE_LAST)
			O_LOCAL_RDATA <= regfile[I_LOCAL_ADDR[4:0]];
		else if (I_LOCAL_ADDR == OFS_INCOMPLETE_STATUS)
			O_LOCAL_RDATA <= status_rd;
		else if (I_LOCAL_ADDR == OFS_CLOCK_FORMAT)
			O_LOCAL_RDATA <= format_rd;
		else if (I_LOCAL_ADDR == OFS_IRQ_STATUS)
			O_LOCAL_RDATA <= {5'h00, irq_status};
		else if (I_LOCAL_ADDR == OFS_IRQ_MASK)
			O_LOCAL_RDATA <= {5'h00, irq_mask};
		else
			O_LOCAL_RDATA <= 8'h00;
	end
endmodule // ssp_dev
`default_nettype wire

// ==== logic/ssp_pkg.sv ====
`default_nettype none
package ssp_pkg;
	// clock and link timing
	localparam int CORE_CLK_NS = 50;
	localparam int HOST_HALF_NS = 500;
	localparam int HOST_HALF_CYC = (HOST_HALF_NS / CORE_CLK_NS < 1) ? 1 : HOST_HALF_NS / CORE_CLK_NS;
	localparam logic [4:0] HALF_LAST = 5'(HOST_HALF_CYC - 1);
	// local port map
	localparam logic [5:0] OFS_REGFILE_LAST = 6'h1F;
	localparam logic [5:0] OFS_INCOMPLETE_STATUS = 6'h20;
	localparam logic [5:0] OFS_CLOCK_FORMAT = 6'h21;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h22;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h23;
	// field positions
	localparam int INCOMPLETE_BIT = 0;
	localparam int WRITE_COLLISION_FLAG_BIT = 1;
	localparam int SELECT_PIN_CONTROL_BIT = 2;
	localparam int MLS_BIT = 3;
	localparam int CAPTURE_EDGE_SELECT_BIT = 4;
	localparam int CKPOL_BIT = 5;
	localparam int CMD_RW_BIT = 7;
	localparam int EV_WRITE_BIT = 0;
	localparam int EV_INCOMPLETE_BIT = 1;
	localparam int EV_COLLISION_BIT = 2;
	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] FORMAT_RESET = 8'h00;
	localparam logic [7:0] REGFILE_RESET = 8'h00;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	// misc counts
	localparam int REG_COUNT = 32;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] XFER_BIT_LAST = 4'hF;
	typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DONE} ssp_phase_e;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LEAD, ST_TRAIL, ST_HOLD, ST_GAP} ssp_host_state_e;
endpackage
`default_nettype wire

// ==== logic/ssp_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ssp_link_if;
	logic sclk;
	logic ss_n;
	logic mosi;
	logic miso;
	logic if_sel;
	modport dev (input sclk, input ss_n, input mosi, input if_sel, output miso);
	modport host (output sclk, output ss_n, output mosi, output if_sel, input miso);
endinterface
`default_nettype wire

// ==== logic/ssp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssp_host
	import ssp_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	ssp_link_if.host link,
	input wire logic I_START,
	input wire logic I_READ,
	input wire logic [4:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_CLOCK_IDLE_POLARITY,
	input wire logic I_CAPTURE_EDGE_SELECT,
	input wire logic I_SHIFT_ORDER_SELECT,
	output logic O_BUSY,
	output logic O_DONE,
	output logic [7:0] O_RDATA
);
	ssp_host_state_e state;
	logic [4:0] half_cnt;
	logic half_end;
	logic [3:0] bit_idx;
	logic [15:0] word;
	logic idle_lvl;
	logic lead_cap;
	logic msb_first;
	logic miso_s1;
	logic miso_s2;
	logic [7:0] rx;
	logic [3:0] next_idx;

	function automatic logic tx_bit(input logic [15:0] w, input logic [3:0] idx, input logic msb);
		logic [7:0] b;
		b = idx[3] ? w[7:0] : w[15:8];
		return msb ? b[3'(BIT_LAST - idx[2:0])] : b[idx[2:0]];
	endfunction

	// miso synchroniser
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end
		else
		begin
			miso_s1 <= link.miso;
			miso_s2 <= miso_s1;
		end
	end

	assign half_end = (half_cnt == HALF_LAST);
	assign next_idx = (state == ST_SETUP) ? 4'h0 : 4'(bit_idx + 4'h1);

	// half period timer
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			half_cnt <= 5'h00;
		else if (state == ST_IDLE || half_end)
			half_cnt <= 5'h00;
		else
			half_cnt <= 5'(half_cnt + 5'h01);
	end

	// transfer sequencer
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			state <= ST_IDLE;
			link.ss_n <= 1'b1;
			link.sclk <= 1'b1;
			link.mosi <= 1'b0;
			link.if_sel <= 1'b0;
			bit_idx <= 4'h0;
			word <= 16'h0000;
			idle_lvl <= 1'b1;
			lead_cap <= 1'b0;
			msb_first <= 1'b0;
			rx <= 8'h00;
			O_BUSY <= 1'b0;
			O_DONE <= 1'b0;
			O_RDATA <= 8'h00;
		end
		else
		begin
			link.if_sel <= 1'b1; // [RQ1]
			O_DONE <= 1'b0;
			unique case (state)
				ST_IDLE:
				begin
					link.sclk <= ~I_CLOCK_IDLE_POLARITY; // [RQ4]
					if (I_START)
					begin
						idle_lvl <= ~I_CLOCK_IDLE_POLARITY; // [RQ13]
						lead_cap <= I_CAPTURE_EDGE_SELECT;
						msb_first <= I_SHIFT_ORDER_SELECT;
						word <= {I_READ, 2'b00, I_ADDR, I_READ ? 8'h00 : I_WDATA}; // [RQ14] [RQ15]
						link.ss_n <= 1'b0; // [RQ12]
						bit_idx <= 4'h0;
						rx <= 8'h00;
						O_BUSY <= 1'b1;
						state <= ST_SETUP;
					end
				end
				ST_SETUP, ST_TRAIL:
				begin
					if (half_end)
					begin
						if (state == ST_TRAIL)
						begin
							link.sclk <= idle_lvl;
							if (!lead_cap && bit_idx[3])
								rx[msb_first ? 3'(BIT_LAST - bit_idx[2:0]) : bit_idx[2:0]] <= miso_s2; // [RQ16]
						end
						if (state == ST_TRAIL && bit_idx == XFER_BIT_LAST)
							state <= ST_HOLD;
						else
						begin
							bit_idx <= next_idx;
							// data moves on the edge opposite capture, the first bit at the end of setup
							if (lead_cap || state == ST_SETUP)
								link.mosi <= tx_bit(word, next_idx, msb_first); // [RQ5]
							state <= ST_LEAD;
						end
					end
				end
				ST_LEAD:
				begin
					if (half_end)
					begin
						link.sclk <= ~idle_lvl;
						if (!lead_cap)
							link.mosi <= tx_bit(word, bit_idx, msb_first); // [RQ5]
						if (lead_cap && bit_idx[3])
							rx[msb_first ? 3'(BIT_LAST - bit_idx[2:0]) : bit_idx[2:0]] <= miso_s2; // [RQ16]
						state <= ST_TRAIL;
					end
				end
				ST_HOLD:
				begin
					if (half_end)
					begin
						link.ss_n <= 1'b1;
						state <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					if (half_end)
					begin
						O_BUSY <= 1'b0;
						O_DONE <= 1'b1;
						O_RDATA <= rx;
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule // ssp_host
`default_nettype wire

// ==== verification/ssp_link_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssp_link_properties (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic if_sel
);
	logic sclk_q;
	logic ss_q;
	logic idle_lvl;
	logic [5:0] edge_cnt;
	logic [3:0] miso_age;
	logic cap;
	// every clock edge inside a frame
	assign cap = !ss_n && !ss_q && (sclk != sclk_q);
	default clocking dflt @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_N);
	// pin history
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sclk_q <= 1'b1;
			ss_q <= 1'b1;
		end
		else
		begin
			sclk_q <= sclk;
			ss_q <= ss_n;
		end
	end
	// clock edges within a frame
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			edge_cnt <= 6'h00;
		else if (ss_n || ss_q)
			edge_cnt <= 6'h00;
		else if (sclk != sclk_q)
			edge_cnt <= edge_cnt + 6'h01;
	end
	// idle level seen before the first edge
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			idle_lvl <= 1'b1;
		else if (edge_cnt == 6'h00 && sclk == sclk_q)
			idle_lvl <= sclk;
	end
	// cycles since miso last moved
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			miso_age <= 4'h0;
		else if ($changed(miso))
			miso_age <= 4'h0;
		else if (miso_age != 4'hF)
			miso_age <= miso_age + 4'h1;
	end
	miso_idle_a: assert property (ss_n [*6] |-> !miso)
		else $error("miso driven while deselected");
	select_lead_a: assert property ($fell(ss_n) |-> ##1 $stable(sclk) [*8])
		else $error("clock moved right after select");
	select_trail_a: assert property ($rose(ss_n) |-> ##1 $stable(sclk) [*8])
		else $error("clock moved right after deselect");
	edge_count_a: assert property ($rose(ss_n) |-> edge_cnt == 6'd32)
		else $error("frame did not carry sixteen bits");
	idle_level_a: assert property ($rose(ss_n) |-> sclk == idle_lvl)
		else $error("clock not back at idle level");
	spi_mode_a: assert property (!ss_n |-> if_sel)
		else $error("frame without serial mode select");
	miso_cmd_a: assert property ((!ss_n && edge_cnt < 6'h10) |-> !miso)
		else $error("miso active during command byte");
	miso_settle_a: assert property (cap |-> miso_age >= 4'd4)
		else $error("miso not settled at capture");
	frame_c: cover property ($rose(ss_n) && edge_cnt == 6'd32);
	read_c: cover property (cap && miso);
	idle_low_c: cover property ($rose(ss_n) && !sclk && mosi == 1'b0);
endmodule // ssp_link_properties
`default_nettype wire

// ==== verification/spi_slave_register_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_slave_register_port_test
	import ssp_pkg::*;
;
	logic clk, rst_n, start, rd, pol, edg, ord, lwr, lrd, busy, done, irq;
	logic [4:0] addr;
	logic [5:0] laddr;
	logic [7:0] wdata, lwdata, rdata, lrdata, got, f, v;
	int err_total, compares;
	ssp_link_if ssp_link_if_i ();
	ssp_host ssp_host_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .link(ssp_link_if_i.host), .I_START(start),
		.I_READ(rd), .I_ADDR(addr), .I_WDATA(wdata), .I_CLOCK_IDLE_POLARITY(pol), .I_CAPTURE_EDGE_SELECT(edg),
		.I_SHIFT_ORDER_SELECT(ord), .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata));
	ssp_dev ssp_dev_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .link(ssp_link_if_i.dev), .I_LOCAL_ADDR(laddr),
		.I_LOCAL_WDATA(lwdata), .I_LOCAL_WR(lwr), .I_LOCAL_RD(lrd), .O_LOCAL_RDATA(lrdata), .O_IRQ(irq));
	ssp_link_properties ssp_link_properties_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .sclk(ssp_link_if_i.sclk),
		.ss_n(ssp_link_if_i.ss_n), .mosi(ssp_link_if_i.mosi), .miso(ssp_link_if_i.miso),
		.if_sel(ssp_link_if_i.if_sel));
	task automatic stop_test;
		$display("compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic lw(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		laddr <= a;
		lwdata <= d;
		lwr <= 1'b1;
		@(posedge clk);
		lwr <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		@(posedge clk);
		laddr <= a;
		lrd <= 1'b1;
		@(posedge clk);
		lrd <= 1'b0;
		#1 chk(lrdata, e);
	endtask
	task automatic setfmt(input logic [7:0] x);
		lw(OFS_CLOCK_FORMAT, x);
		pol <= x[CKPOL_BIT];
		edg <= x[CAPTURE_EDGE_SELECT_BIT];
		ord <= x[MLS_BIT];
		repeat (4) @(posedge clk);
	endtask
	// one host frame; col adds a local write to the same register mid-frame
	task automatic xfer(input logic r, input logic [4:0] a, input logic [7:0] d, input logic col);
		int n;
		@(posedge clk);
		rd <= r;
		addr <= a;
		wdata <= d;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		#1 chk({7'h00, busy}, 8'h01);
		if (col)
		begin
			repeat (150) @(posedge clk);
			lw({1'b0, a}, ~d);
		end
		for (n = 0; n < 1000 && done !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: frame never finished", $time);
		end
		got = rdata;
		chk({7'h00, busy}, 8'h00);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test;
	end
	initial
	begin
		{rst_n, start, rd, pol, edg, ord, lwr, lrd} = 8'h00;
		{addr, laddr, wdata, lwdata} = 27'h0;
		err_total = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(OFS_INCOMPLETE_STATUS, STATUS_RESET);
		rchk(OFS_CLOCK_FORMAT, FORMAT_RESET);
		rchk(OFS_IRQ_STATUS, 8'h00);
		rchk(6'h3F, 8'h00);
		$display("test reset_values done");
		xfer(1'b0, 5'h05, 8'hA5, 1'b0);
		rchk(6'h05, 8'hA5);
		rchk(OFS_IRQ_STATUS, 8'h01);
		chk({7'h00, irq}, 8'h00);
		lw(OFS_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h01);
		lw(OFS_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		rchk(OFS_IRQ_STATUS, 8'h00);
		lw(OFS_IRQ_MASK, 8'h00);
		$display("test unselected_write_irq done");
		lw(OFS_CLOCK_FORMAT, 8'hFD);
		rchk(OFS_CLOCK_FORMAT, 8'h3C);
		lw(OFS_INCOMPLETE_STATUS, 8'hFE);
		rchk(OFS_INCOMPLETE_STATUS, 8'h00);
		$display("test read_zero_bits done");
		for (int i = 0; i < 4; i++)
		begin
			f = {2'b00, i[1], i[0], i[1] ^ i[0], 3'b100};
			v = 8'hC1 + 8'(i);
			setfmt(f);
			xfer(1'b0, 5'(8 + i), v, 1'b0);
			rchk(6'(8 + i), v);
			xfer(1'b1, 5'(8 + i), 8'h00, 1'b0);
			chk(got, v);
		end
		$display("test clock_modes done");
		xfer(1'b0, 5'h13, 8'h3C, 1'b1);
		rchk(6'h13, 8'h3C);
		rchk(OFS_CLOCK_FORMAT, f | 8'h02);
		rchk(OFS_IRQ_STATUS, 8'h05);
		lw(OFS_CLOCK_FORMAT, f);
		rchk(OFS_CLOCK_FORMAT, f);
		$display("test collision done");
		lw(OFS_CLOCK_FORMAT, 8'h30);
		pol <= 1'b0;
		repeat (6) @(posedge clk);
		lw(OFS_CLOCK_FORMAT, 8'h34);
		pol <= 1'b1;
		rchk(OFS_INCOMPLETE_STATUS, 8'h01);
		rchk(OFS_IRQ_STATUS, 8'h07);
		lw(OFS_INCOMPLETE_STATUS, 8'h00);
		rchk(OFS_INCOMPLETE_STATUS, 8'h00);
		$display("test incomplete done");
		stop_test;
	end
endmodule // spi_slave_register_port_test
`default_nettype wire
